// ==== shared/wec_pkg.sv ====
// Shared constants for the watchdog and extended interrupt control block
package wec_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFF_UNLOCK_KEY  = 8'h00;
	localparam logic [7:0] OFF_AUTOCLEAR   = 8'h04;
	localparam logic [7:0] OFF_IRQ_STATUS  = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK    = 8'h0C;
	localparam logic [7:0] OFF_EXT_PENDING = 8'h10;
	localparam logic [7:0] OFF_WDCTRL      = 8'hD8;
	localparam logic [7:0] OFF_XIRQ_EN     = 8'hE8;
	localparam logic [7:0] OFF_XIRQ_PRIO   = 8'hF8;

	// ****************************************
	// Watchdog control field positions
	// ****************************************
	localparam int WDC_SMOD1     = 7;
	localparam int WDC_POR       = 6;
	localparam int WDC_IRQ_FLAG  = 3;
	localparam int WDC_RST_CAUSE = 2;
	localparam int WDC_RST_EN    = 1;
	localparam int WDC_RESTART   = 0;

	// ****************************************
	// Other field positions
	// ****************************************
	localparam int XIRQ_WDOG_BIT   = 4;
	localparam int AUTOCLEAR_LSB   = 4;
	localparam int IST_TIMEOUT     = 0;
	localparam int IST_WDOG_RESET  = 1;
	localparam int IST_WIDTH       = 2;
	localparam int EXT_IRQ_COUNT   = 4;

	// ****************************************
	// Reset values and fixed patterns
	// ****************************************
	localparam logic [7:0] XIRQ_EN_RSVD_ONES = 8'hE0;
	localparam logic [7:0] KEY_FIRST         = 8'hAA;
	localparam logic [7:0] KEY_SECOND        = 8'h55;
	localparam logic [4:0] XIRQ_RESET        = 5'h00;
	localparam logic [3:0] AUTOCLEAR_RESET   = 4'h0;
	localparam logic [1:0] IST_RESET         = 2'h0;
	localparam logic       POR_FLAG_RESET    = 1'b1;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLOCKS_PER_MACHINE_CYCLE = 4;
	localparam int UNLOCK_MACHINE_CYCLES    = 3;
	localparam int UNLOCK_WINDOW_CLOCKS     = UNLOCK_MACHINE_CYCLES * CLOCKS_PER_MACHINE_CYCLE;
	localparam int WDOG_RESET_DELAY_CLOCKS  = 512;
	localparam int WDOG_TIMEOUT_CLOCKS      = 131072;

endpackage : wec_pkg

// ==== src/wec_sync2.sv ====
// Two-flop synchroniser for a group of pin levels
module wec_sync2 #(
	parameter int W = 1
) (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} wec_sync_s;

	wec_sync_s s;
	wec_sync_s next_s;

	always_comb begin
		next_s      = s;
		next_s.meta = d_i;
		next_s.sync = s.meta;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q_o = s.sync;

endmodule : wec_sync2

// ==== src/wec_wdog_counter.sv ====
// Watchdog core clock counter with restart and timeout pulse
module wec_wdog_counter #(
	parameter int TIMEOUT = wec_pkg::WDOG_TIMEOUT_CLOCKS
) (
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic restart_i,
	output logic      timeout_o
);

	localparam int CW = $clog2(TIMEOUT + 1);
	localparam logic [CW-1:0] LAST = CW'(TIMEOUT - 1);

	typedef struct packed {
		logic [CW-1:0] count;
		logic          timeout;
	} wec_cnt_s;

	wec_cnt_s s;
	wec_cnt_s next_s;

	always_comb begin
		next_s         = s;
		next_s.timeout = 1'b0;
		if (restart_i) begin
			next_s.count = '0;
		end else if (s.count == LAST) begin
			next_s.count   = '0;
			next_s.timeout = 1'b1;
		end else begin
			next_s.count = s.count + CW'(1);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign timeout_o = s.timeout;

endmodule : wec_wdog_counter

// ==== src/wec_top.sv ====
// Watchdog control with extended interrupt enable, priority and auto-clear
module wec_top #(
	parameter int WDOG_TIMEOUT = wec_pkg::WDOG_TIMEOUT_CLOCKS
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        ext_reset_i,
	input  wire logic        power_fail_reset_i,
	input  wire logic [3:0]  ext_irq_i,
	input  wire logic [3:0]  ext_irq_service_i,
	output logic      [3:0]  ext_irq_req_o,
	output logic      [3:0]  ext_irq_prio_o,
	output logic             wdog_irq_req_o,
	output logic             wdog_irq_prio_o,
	output logic             wdog_reset_o,
	output logic             serial1_baud_double_o,
	output logic             irq_o
);

	localparam int WCW = $clog2(wec_pkg::UNLOCK_WINDOW_CLOCKS + 1);
	localparam logic [WCW-1:0] WIN_LOAD = WCW'(wec_pkg::UNLOCK_WINDOW_CLOCKS);
	localparam int RCW = $clog2(wec_pkg::WDOG_RESET_DELAY_CLOCKS);
	localparam logic [RCW-1:0] RST_DELAY_LAST = RCW'(wec_pkg::WDOG_RESET_DELAY_CLOCKS - 1);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic                    smod1;
		logic                    por;
		logic                    irq_flag;
		logic                    rst_cause;
		logic                    rst_en;
		logic                    restart;

		logic [4:0]              xirq_en;
		logic [4:0]              xirq_prio;
		logic [3:0]              autoclear;
		logic [3:0]              pending;
		logic [3:0]              irq_prev;

		logic                    key_armed;
		logic [WCW-1:0]          win_cnt;
		logic                    rst_armed;
		logic [RCW-1:0]          rst_cnt;

		logic [1:0]              ist;
		logic [1:0]              imask;

		logic [31:0]             prdata;
		logic                    pready;
		logic                    pslverr;
		logic [3:0]              ext_req;
		logic [3:0]              ext_prio;
		logic                    wdog_req;
		logic                    wdog_prio;
		logic                    wdog_reset;
		logic                    irq;
	} wec_state_s;

	wec_state_s s;
	wec_state_s next_s;

	logic [3:0] irq_sync;
	logic [1:0] rst_sync;
	logic       timeout;
	logic       counter_restart;

	// ****************************************
	// Pin synchronisers and watchdog counter
	// ****************************************
	wec_sync2 #(
		.W (4)
	) u_irq_sync (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.d_i       (ext_irq_i),
		.q_o       (irq_sync)
	);

	wec_sync2 #(
		.W (2)
	) u_rst_sync (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.d_i       ({power_fail_reset_i, ext_reset_i}),
		.q_o       (rst_sync)
	);

	assign counter_restart = s.restart | s.wdog_reset | rst_sync[0] | rst_sync[1];

	wec_wdog_counter #(
		.TIMEOUT (WDOG_TIMEOUT)
	) u_counter (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.restart_i (counter_restart),
		.timeout_o (timeout)
	);

	// ****************************************
	// Register read mux
	// ****************************************
	function automatic logic [7:0] wec_read(input wec_state_s st, input logic [7:0] addr);
		logic [7:0] r;
		r = 8'h00;
		case (addr)
			wec_pkg::OFF_WDCTRL: begin
				r[wec_pkg::WDC_SMOD1]     = st.smod1;
				r[wec_pkg::WDC_POR]       = st.por;
				r[wec_pkg::WDC_IRQ_FLAG]  = st.irq_flag;
				r[wec_pkg::WDC_RST_CAUSE] = st.rst_cause;
				r[wec_pkg::WDC_RST_EN]    = st.rst_en;
				r[wec_pkg::WDC_RESTART]   = st.restart;
			end
			wec_pkg::OFF_XIRQ_EN: r = wec_pkg::XIRQ_EN_RSVD_ONES | {3'h0, st.xirq_en};
			wec_pkg::OFF_XIRQ_PRIO: r = {3'h0, st.xirq_prio};
			wec_pkg::OFF_AUTOCLEAR: r = {st.autoclear, 4'h0};
			wec_pkg::OFF_IRQ_STATUS: r = {6'h00, st.ist};
			wec_pkg::OFF_IRQ_MASK: r = {6'h00, st.imask};
			wec_pkg::OFF_EXT_PENDING: r = {4'h0, st.pending};
			wec_pkg::OFF_UNLOCK_KEY: r = {7'h00, (st.win_cnt != '0)};
			default: r = 8'h00;
		endcase
		return r;
	endfunction : wec_read

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic wec_hit(input logic [7:0] addr);
		logic h;
		h = 1'b0;
		case (addr)
			wec_pkg::OFF_WDCTRL,
			wec_pkg::OFF_XIRQ_EN,
			wec_pkg::OFF_XIRQ_PRIO,
			wec_pkg::OFF_AUTOCLEAR,
			wec_pkg::OFF_IRQ_STATUS,
			wec_pkg::OFF_IRQ_MASK,
			wec_pkg::OFF_EXT_PENDING,
			wec_pkg::OFF_UNLOCK_KEY: h = 1'b1;
			default: h = 1'b0;
		endcase
		return h;
	endfunction : wec_hit

	// ****************************************
	// Next state
	// ****************************************
	logic       setup;
	logic       wr;
	logic       win_open;
	logic       key_first;
	logic       key_second;
	logic       ext_rst;
	logic       pf_rst;
	logic [7:0] wd;
	logic [3:0] rise;

	always_comb begin
		next_s            = s;
		setup             = psel_i & ~penable_i;
		wr                = psel_i & penable_i & s.pready & pwrite_i;
		win_open          = (s.win_cnt != '0);
		wd                = pwdata_i[7:0];
		key_first         = (wd == wec_pkg::KEY_FIRST);
		key_second        = (wd == wec_pkg::KEY_SECOND);
		ext_rst           = rst_sync[0];
		pf_rst            = rst_sync[1];
		rise              = irq_sync & ~s.irq_prev;
		next_s.irq_prev   = irq_sync;
		next_s.pready     = 1'b0;
		next_s.pslverr    = 1'b0;
		next_s.wdog_reset = 1'b0;
		next_s.restart    = 1'b0;

		// ****************************************
		// APB answer, no wait states
		// ****************************************
		if (setup) begin
			next_s.pready  = 1'b1;
			next_s.pslverr = ~wec_hit(paddr_i);
			next_s.prdata  = {24'h000000, wec_read(s, paddr_i)};
		end

		// ****************************************
		// Unlock window
		// ****************************************
		if (win_open) begin
			next_s.win_cnt = s.win_cnt - WCW'(1);
		end
		if (wr) begin
			next_s.key_armed = 1'b0;
			if (paddr_i == wec_pkg::OFF_UNLOCK_KEY) begin
				if (s.key_armed && key_second) begin
					next_s.win_cnt = WIN_LOAD;
				end else begin
					next_s.key_armed = key_first;
				end
			end
		end

		// ****************************************
		// Register writes
		// ****************************************
		if (wr) begin
			case (paddr_i)
				wec_pkg::OFF_WDCTRL: begin
					next_s.smod1     = wd[wec_pkg::WDC_SMOD1];
					next_s.rst_cause = wd[wec_pkg::WDC_RST_CAUSE];
					if (win_open) begin
						next_s.por      = wd[wec_pkg::WDC_POR];
						next_s.irq_flag = wd[wec_pkg::WDC_IRQ_FLAG];
						next_s.rst_en   = wd[wec_pkg::WDC_RST_EN];
						next_s.restart  = wd[wec_pkg::WDC_RESTART];
					end
				end
				wec_pkg::OFF_XIRQ_EN: next_s.xirq_en = wd[4:0];
				wec_pkg::OFF_XIRQ_PRIO: next_s.xirq_prio = wd[4:0];
				wec_pkg::OFF_AUTOCLEAR: next_s.autoclear = wd[7:4];
				wec_pkg::OFF_IRQ_STATUS: next_s.ist = s.ist & ~wd[1:0];
				wec_pkg::OFF_IRQ_MASK: next_s.imask = wd[1:0];
				wec_pkg::OFF_EXT_PENDING: next_s.pending = s.pending & ~wd[3:0];
				default: begin
				end
			endcase
		end

		// ****************************************
		// External pending flags, set wins over clear
		// ****************************************
		next_s.pending = next_s.pending & ~(ext_irq_service_i & s.autoclear);
		next_s.pending = next_s.pending | rise;

		// ****************************************
		// Watchdog timeout and delayed reset
		// ****************************************
		if (s.rst_armed) begin
			if (s.restart) begin
				next_s.rst_armed = 1'b0;
			end else if (s.rst_cnt == '0) begin
				next_s.rst_armed  = 1'b0;
				next_s.wdog_reset = 1'b1;
				next_s.rst_cause  = 1'b1;
				next_s.ist[wec_pkg::IST_WDOG_RESET] = 1'b1;
			end else begin
				next_s.rst_cnt = s.rst_cnt - RCW'(1);
			end
		end
		if (timeout) begin
			next_s.irq_flag = 1'b1;
			next_s.ist[wec_pkg::IST_TIMEOUT] = 1'b1;
			if (s.rst_en) begin
				next_s.rst_armed = 1'b1;
				next_s.rst_cnt   = RST_DELAY_LAST;
			end
		end

		// ****************************************
		// External and power-fail resets
		// ****************************************
		if (ext_rst | pf_rst) begin
			next_s.smod1      = 1'b0;
			next_s.irq_flag   = 1'b0;
			next_s.restart    = 1'b0;
			next_s.rst_armed  = 1'b0;
			next_s.key_armed  = 1'b0;
			next_s.win_cnt    = '0;
			next_s.wdog_reset = 1'b0;
		end
		if (pf_rst) begin
			next_s.rst_cause = 1'b0;
		end

		// ****************************************
		// Registered outputs
		// ****************************************
		next_s.wdog_req  = next_s.irq_flag & next_s.xirq_en[wec_pkg::XIRQ_WDOG_BIT];
		next_s.wdog_prio = next_s.xirq_prio[wec_pkg::XIRQ_WDOG_BIT];
		next_s.ext_req   = next_s.pending & next_s.xirq_en[3:0];
		next_s.ext_prio  = next_s.xirq_prio[3:0];
		next_s.irq       = |(next_s.ist & next_s.imask);
	end

	// ****************************************
	// State register, rst_i is the power-on reset
	// ****************************************
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s           <= '0;
			s.por       <= wec_pkg::POR_FLAG_RESET;
			s.rst_en    <= 1'b0;
			s.rst_cause <= 1'b0;
			s.xirq_en   <= wec_pkg::XIRQ_RESET;
			s.xirq_prio <= wec_pkg::XIRQ_RESET;
			s.autoclear <= wec_pkg::AUTOCLEAR_RESET;
			s.ist       <= wec_pkg::IST_RESET;
			s.imask     <= wec_pkg::IST_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata_o              = s.prdata;
	assign pready_o              = s.pready;
	assign pslverr_o             = s.pslverr;
	assign ext_irq_req_o         = s.ext_req;
	assign ext_irq_prio_o        = s.ext_prio;
	assign wdog_irq_req_o        = s.wdog_req;
	assign wdog_irq_prio_o       = s.wdog_prio;
	assign wdog_reset_o          = s.wdog_reset;
	assign serial1_baud_double_o = s.smod1;
	assign irq_o                 = s.irq;

endmodule : wec_top

// ==== tb/wec_assertions.sv ====
// Port-level assertions for the watchdog control block
module wec_checker #(
	parameter int WDOG_TIMEOUT = wec_pkg::WDOG_TIMEOUT_CLOCKS
) (
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        ext_reset_i,
	input wire logic        power_fail_reset_i,
	input wire logic [3:0]  ext_irq_req_o,
	input wire logic [3:0]  ext_irq_prio_o,
	input wire logic        wdog_irq_prio_o,
	input wire logic        wdog_reset_o,
	input wire logic        serial1_baud_double_o
);
	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	logic rd;
	logic wr;
	assign rd = pready_o && psel_i && penable_i && !pwrite_i;
	assign wr = pready_o && psel_i && penable_i && pwrite_i;
	AST_SETUP_ANSWER:
		assert property (psel_i && !penable_i |=> pready_o) else $error("no answer");
	AST_READY_PULSE:
		assert property (pready_o |=> !pready_o) else $error("pready too long");
	AST_UNMAPPED:
		assert property (pready_o && psel_i |-> pslverr_o == !(paddr_i inside
			{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'hD8, 8'hE8, 8'hF8})) else $error("slverr");
	AST_ENABLE_RSVD:
		assert property (rd && paddr_i == 8'hE8 |-> prdata_o[7:5] == 3'h7) else $error("rsvd");
	AST_CTRL_ZERO:
		assert property (rd && paddr_i == 8'hD8 |-> prdata_o[5:4] == 2'h0) else $error("ctrl");
	AST_PRIO_OUT:
		assert property (wr && paddr_i == 8'hF8 |-> ##2
			{wdog_irq_prio_o, ext_irq_prio_o} == $past(pwdata_i[4:0], 2)) else $error("prio");
	AST_EXT_RESET:
		assert property (ext_reset_i [*6] |-> !serial1_baud_double_o && !wdog_reset_o)
			else $error("ext reset");
	AST_PF_RESET:
		assert property (power_fail_reset_i [*6] |-> !serial1_baud_double_o && !wdog_reset_o)
			else $error("pf reset");
	AST_WDOG_PULSE:
		assert property (wdog_reset_o |=> !wdog_reset_o [*8]) else $error("wdog pulse");
	cover property (wdog_reset_o);
	cover property (pslverr_o);
	cover property (ext_irq_req_o != 4'h0);
endmodule : wec_checker

bind wec_top wec_checker #(.WDOG_TIMEOUT(WDOG_TIMEOUT)) u_wec_checker (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .ext_reset_i(ext_reset_i),
	.power_fail_reset_i(power_fail_reset_i), .ext_irq_req_o(ext_irq_req_o),
	.ext_irq_prio_o(ext_irq_prio_o), .wdog_irq_prio_o(wdog_irq_prio_o),
	.wdog_reset_o(wdog_reset_o), .serial1_baud_double_o(serial1_baud_double_o)
);

// ==== tb/testbench.sv ====
// Self-checking bench for the watchdog control block
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WT = 1024;
	logic        sys_clk_i, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic        ext_reset_i = 1'b0, power_fail_reset_i = 1'b0, e, seen;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, r;
	logic [3:0]  ext_irq_i = 4'h0, ext_irq_service_i = 4'h0, ext_irq_req_o, ext_irq_prio_o;
	logic        pready_o, pslverr_o, wdog_irq_req_o, wdog_irq_prio_o, wdog_reset_o;
	logic        serial1_baud_double_o, irq_o;
	int          errors = 0, n_tests = 0, cycles = 0, n;

	wec_top #(.WDOG_TIMEOUT(WT)) uut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .ext_reset_i(ext_reset_i),
		.power_fail_reset_i(power_fail_reset_i), .ext_irq_i(ext_irq_i),
		.ext_irq_service_i(ext_irq_service_i), .ext_irq_req_o(ext_irq_req_o),
		.ext_irq_prio_o(ext_irq_prio_o), .wdog_irq_req_o(wdog_irq_req_o),
		.wdog_irq_prio_o(wdog_irq_prio_o), .wdog_reset_o(wdog_reset_o),
		.serial1_baud_double_o(serial1_baud_double_o), .irq_o(irq_o)
	);

	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic test_done;
		if (errors == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, x, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= {24'h0, d};
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		do @(posedge sys_clk_i); while (pready_o !== 1'b1);
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : apb
	task automatic rc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 8'h00);
		chk("read", r, x);
	endtask : rc
	task automatic unl;
		apb(1'b1, 8'h00, 8'hAA);
		apb(1'b1, 8'h00, 8'h55);
	endtask : unl
	task automatic do_rst;
		rst_i <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : do_rst

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_por;
		rc(8'hD8, 32'h40);
		rc(8'hE8, 32'hE0);
		apb(1'b0, 8'h20, 8'h00);
		chk("slverr", {31'h0, e}, 32'h1);
		chk("rdata", r, 32'h0);
	endtask : t_por
	task automatic t_prot;
		apb(1'b1, 8'hD8, 8'h02);
		rc(8'hD8, 32'h40);
		unl;
		rc(8'h00, 32'h01);
		apb(1'b1, 8'hD8, 8'h02);
		rc(8'hD8, 32'h02);
		repeat (12) @(posedge sys_clk_i);
		rc(8'h00, 32'h00);
		apb(1'b1, 8'hD8, 8'h80);
		rc(8'hD8, 32'h82);
		chk("baud", {31'h0, serial1_baud_double_o}, 32'h1);
		apb(1'b1, 8'hF8, 8'h15);
		repeat (2) @(posedge sys_clk_i);
		chk("prio", {27'h0, wdog_irq_prio_o, ext_irq_prio_o}, 32'h15);
	endtask : t_prot
	task automatic t_wdog;
		apb(1'b1, 8'hE8, 8'h10);
		do @(posedge sys_clk_i); while (wdog_irq_req_o !== 1'b1);
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (wdog_reset_o !== 1'b1);
		chk("delay", n, 512);
		rc(8'hD8, 32'h8E);
		ext_reset_i <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		ext_reset_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		rc(8'hD8, 32'h06);
		power_fail_reset_i <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		power_fail_reset_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		rc(8'hD8, 32'h02);
		do_rst;
		rc(8'hD8, 32'h40);
	endtask : t_wdog
	task automatic t_noewt;
		apb(1'b1, 8'h0C, 8'h01);
		do @(posedge sys_clk_i); while (irq_o !== 1'b1);
		chk("wreq", {31'h0, wdog_irq_req_o}, 32'h0);
		rc(8'hD8, 32'h48);
		seen = 1'b0;
		repeat (600) begin
			@(posedge sys_clk_i);
			seen = seen | wdog_reset_o;
		end
		chk("wrst", {31'h0, seen}, 32'h0);
		rc(8'hD8, 32'h48);
		apb(1'b1, 8'h0C, 8'h00);
		repeat (2) @(posedge sys_clk_i);
		chk("masked", {31'h0, irq_o}, 32'h0);
		apb(1'b1, 8'h08, 8'h01);
		apb(1'b1, 8'h0C, 8'h01);
		repeat (2) @(posedge sys_clk_i);
		chk("cleared", {31'h0, irq_o}, 32'h0);
		unl;
		apb(1'b1, 8'hD8, 8'h41);
		rc(8'hD8, 32'h40);
		repeat (990) @(posedge sys_clk_i);
		rc(8'hD8, 32'h40);
	endtask : t_noewt
	task automatic t_ext;
		apb(1'b1, 8'hE8, 8'h0F);
		ext_irq_i <= 4'h3;
		repeat (6) @(posedge sys_clk_i);
		chk("ereq", {28'h0, ext_irq_req_o}, 32'h3);
		apb(1'b1, 8'h04, 8'h10);
		ext_irq_service_i <= 4'h3;
		@(posedge sys_clk_i);
		ext_irq_service_i <= 4'h0;
		repeat (3) @(posedge sys_clk_i);
		chk("autoclr", {28'h0, ext_irq_req_o}, 32'h2);
		apb(1'b1, 8'h10, 8'h02);
		repeat (2) @(posedge sys_clk_i);
		chk("w1c", {28'h0, ext_irq_req_o}, 32'h0);
		ext_irq_i <= 4'h0;
	endtask : t_ext

	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			test_done;
		end
	end

	initial begin
		do_rst;
		t_por;
		t_prot;
		t_wdog;
		t_noewt;
		t_ext;
		test_done;
	end
endmodule : testbench
